//--- core/error_led_selftest_status.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - The LED source follows control bits 14:13: summary, cache off, either, or dark.
// - During power-up the LED is lit exactly when the error-summary bit 31 is set.
// - The control register sits at base plus 24 hex and the bus error register at base plus 4 hex.
// - The result register sits at base plus 0C hex.
// - The node base is E1880000 for slot 1 plus 80000 hex per later slot, up to slot 14.
// - A self-test failure leaves its test number, 1 to 57, in result bits 31:24.
// - CPU/memory failures add 60 and multiprocessor failures add 90 to the test number.
// - The failing value in the top byte is held as two BCD digits.
// - Bus error bit 10 is set only for a processor self-test failure.
// - Bus adapter failures are recorded only by the boot processor.
module error_led_selftest_status (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [3:0] slotNum, // Backplane slot, 1 to 14
  input wire logic isBootProc, // This node is the boot processor
  input wire logic powerUpPhase, // High while power-up is in progress
  input wire logic cacheOff, // Backup cache disabled status
  input wire logic errSummarySet, // Pulse: error summary event
  input wire logic failValid, // Pulse: self-test failure report
  input wire err_status_pkg::fail_family_e failFamily, // Family of failing test
  input wire logic [6:0] failTestNum, // Failing test number, binary
  input wire logic [31:0] busAddr, // Longword byte address
  input wire logic busRead, // Read strobe, one cycle
  input wire logic busWrite, // Write strobe, one cycle
  input wire logic [31:0] busWdata, // Write data
  output logic [31:0] busRdata, // Read data, registered
  output logic busAck, // Access taken, registered pulse
  output logic errorLed // Front-panel error LED, high lit
);

  // Binary 0..99 to two BCD digits
  function automatic logic [7:0] toBcd(input logic [7:0] bin);
    logic [3:0] tens;
    logic [7:0] rest;
    tens = 4'h0;
    rest = bin;
    for (int i = 0; i < 9; i++) begin
      if (rest >= 8'h0A) begin
        rest = rest - 8'h0A;
        tens = tens + 4'h1;
      end
    end
    return {tens, rest[3:0]};
  endfunction : toBcd

  // Node base of a slot; zero for an empty slot number
  function automatic logic [31:0] nodeBase(input logic [3:0] slot);
    logic [31:0] idx;
    idx = {28'h0000000, slot - err_status_pkg::SLOT_FIRST};
    if (slot < err_status_pkg::SLOT_FIRST || slot > err_status_pkg::SLOT_LAST) begin
      return 32'h00000000;
    end
    return err_status_pkg::SLOT1_BASE + 32'(idx * err_status_pkg::SLOT_STRIDE);
  endfunction : nodeBase

  logic [31:0] controlReg, controlNext;
  logic [31:0] resultReg, resultNext;
  logic summaryReg, summaryNext;
  logic cpuFailReg, cpuFailNext;
  logic [31:0] rdataReg, rdataNext;
  logic ackReg, ackNext;
  logic inWindow, hitStatus, hitResult, hitControl, hitAny;
  logic recordFail;
  logic [7:0] failByte;
  logic [31:0] statusView;

  // Address decode against own slot window
  always_comb begin
    inWindow = ((busAddr & err_status_pkg::WINDOW_MASK) == nodeBase(slotNum)) && (nodeBase(slotNum) != 32'h00000000);
    hitStatus = inWindow && (busAddr[18:0] == err_status_pkg::BUS_ERROR_STATUS_OFS);
    hitControl = inWindow && (busAddr[18:0] == err_status_pkg::PROCESSOR_CONTROL_ZERO_OFS);
    hitResult = inWindow && (busAddr[18:0] == err_status_pkg::GENERAL_PURPOSE_RESULT_OFS);
    hitAny = hitStatus || hitControl || hitResult;
  end

  // Failure value for the top byte
  always_comb begin
    // adapter failures only on boot node
    recordFail = failValid && ((failFamily != err_status_pkg::FAM_ADAPTER) || isBootProc);
    case (failFamily)
      err_status_pkg::FAM_CPU_MEM: failByte = {1'b0, failTestNum} + err_status_pkg::CPU_MEM_BIAS;
      err_status_pkg::FAM_MULTIPROC: failByte = {1'b0, failTestNum} + err_status_pkg::MULTIPROC_BIAS;
      default: failByte = {1'b0, failTestNum};
    endcase
  end

  // Bus error status as software sees it
  always_comb begin
    statusView = 32'h00000000;
    statusView[err_status_pkg::ERR_SUMMARY_BIT] = summaryReg;
    statusView[err_status_pkg::CPU_SELFTEST_BIT] = cpuFailReg;
  end

  // Control register next value
  always_comb begin
    controlNext = controlReg;
    // LED select rides in bits 14:13
    if (busWrite && hitControl) begin
      controlNext = busWdata;
    end
  end

  // Control register flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      controlReg <= err_status_pkg::CONTROL_RESET;
    end else begin
      controlReg <= controlNext;
    end
  end

  // Result register; a failure beats a same-cycle write in bits 31:24
  always_comb begin
    resultNext = resultReg;
    // software write of the whole longword
    if (busWrite && hitResult) begin
      resultNext = busWdata;
    end
    if (recordFail) begin
      // BCD test number in top byte
      resultNext[31:err_status_pkg::FAIL_BYTE_LSB] = toBcd(failByte);
    end
  end

  // Result register flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resultReg <= err_status_pkg::RESULT_RESET;
    end else begin
      resultReg <= resultNext;
    end
  end

  // Status flags: summary is write-one-clear, event wins
  always_comb begin
    summaryNext = summaryReg;
    cpuFailNext = cpuFailReg;
    if (busWrite && hitStatus && busWdata[err_status_pkg::ERR_SUMMARY_BIT]) begin
      summaryNext = 1'h0;
    end
    // Set last so a same-cycle event is kept
    if (errSummarySet) begin
      summaryNext = 1'h1;
    end
    if (recordFail) begin
      cpuFailNext = (failFamily == err_status_pkg::FAM_SELFTEST);
    end
  end

  // Status flag flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      summaryReg <= err_status_pkg::SUMMARY_RESET;
      cpuFailReg <= err_status_pkg::CPU_FAIL_RESET;
    end else begin
      summaryReg <= summaryNext;
      cpuFailReg <= cpuFailNext;
    end
  end

  // Bus answer: one-cycle ack, read data held until the next read hit
  always_comb begin
    ackNext = (busRead || busWrite) && hitAny;
    rdataNext = rdataReg;
    if (busRead && hitAny) begin
      if (hitStatus) begin
        rdataNext = statusView;
      end else if (hitResult) begin
        rdataNext = resultReg;
      end else begin
        rdataNext = controlReg;
      end
    end
  end

  // Bus answer flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdataReg <= err_status_pkg::READ_DATA_RESET;
      ackReg <= err_status_pkg::ACK_RESET;
    end else begin
      rdataReg <= rdataNext;
      ackReg <= ackNext;
    end
  end

  assign busRdata = rdataReg;
  assign busAck = ackReg;

  // LED source selection
  always_comb begin
    if (powerUpPhase) begin
      errorLed = summaryReg;
    end else begin
      case (controlReg[err_status_pkg::LED_SEL_HI_BIT:err_status_pkg::LED_SEL_LO_BIT])
        err_status_pkg::LED_SUMMARY: errorLed = summaryReg;
        err_status_pkg::LED_CACHE_OFF: errorLed = cacheOff;
        err_status_pkg::LED_EITHER: errorLed = summaryReg || cacheOff;
        err_status_pkg::LED_DARK: errorLed = 1'b0;
        default: errorLed = 1'b0;
      endcase
    end
  end

endmodule : error_led_selftest_status

`default_nettype wire

//--- shared/err_status_pkg.sv
`default_nettype none
package err_status_pkg;
  // Node space window per slot
  localparam logic [31:0] SLOT1_BASE = 32'hE1880000;
  localparam logic [31:0] SLOT_STRIDE = 32'h00080000;
  localparam logic [31:0] WINDOW_MASK = 32'hFFF80000;
  localparam logic [3:0] SLOT_FIRST = 4'h1;
  localparam logic [3:0] SLOT_LAST = 4'hE;
  // Register offsets within the window
  localparam logic [18:0] BUS_ERROR_STATUS_OFS = 19'h00004;
  localparam logic [18:0] GENERAL_PURPOSE_RESULT_OFS = 19'h0000C;
  localparam logic [18:0] PROCESSOR_CONTROL_ZERO_OFS = 19'h00024;
  // Field positions
  localparam int ERR_SUMMARY_BIT = 31;
  localparam int CPU_SELFTEST_BIT = 10;
  localparam int LED_SEL_HI_BIT = 14;
  localparam int LED_SEL_LO_BIT = 13;
  localparam int FAIL_BYTE_LSB = 24;
  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] RESULT_RESET = 32'h00000000;
  localparam logic [31:0] READ_DATA_RESET = 32'h00000000;
  localparam logic SUMMARY_RESET = 1'h0;
  localparam logic CPU_FAIL_RESET = 1'h0;
  localparam logic ACK_RESET = 1'h0;
  // Test number offsets per family
  localparam logic [7:0] CPU_MEM_BIAS = 8'h3C;
  localparam logic [7:0] MULTIPROC_BIAS = 8'h5A;
  // Failing test family codes
  typedef enum logic [1:0] {
    FAM_SELFTEST,
    FAM_CPU_MEM,
    FAM_MULTIPROC,
    FAM_ADAPTER
  } fail_family_e;
  // LED select encodings
  localparam logic [1:0] LED_SUMMARY = 2'h0;
  localparam logic [1:0] LED_CACHE_OFF = 2'h1;
  localparam logic [1:0] LED_EITHER = 2'h2;
  localparam logic [1:0] LED_DARK = 2'h3;
endpackage : err_status_pkg
`default_nettype wire

//--- sim/err_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module err_status_asserts (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic [3:0] slotNum, // Slot
  input wire logic powerUpPhase, // Power-up
  input wire logic errSummarySet, // Summary set
  input wire logic [31:0] busAddr, // Address
  input wire logic busRead, // Read
  input wire logic busWrite, // Write
  input wire logic [31:0] busRdata, // Read data
  input wire logic busAck, // Ack
  input wire logic errorLed // LED
);
  logic [31:0] ofs;
  logic hit;
  // Offset within own window and register hit
  assign ofs = busAddr - 32'hE1880000 - {9'h0, slotNum - 4'h1, 19'h0};
  assign hit = slotNum != 4'h0 && slotNum != 4'hF && (ofs == 32'h4 || ofs == 32'hC || ofs == 32'h24);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_ack: assert property (busRead && hit |=> busAck) else $error("no read ack");
  a_write_ack: assert property (busWrite && hit |=> busAck) else $error("no write ack");
  a_miss_quiet: assert property (!(hit && (busRead || busWrite)) |=> !busAck) else $error("stray ack");
  a_rdata_hold: assert property (!(busRead && hit) |=> $stable(busRdata)) else $error("rdata moved");
  a_status_zero: assert property (
    busAck && $past(busRead) && $past(ofs) == 32'h4
    |-> busRdata[30:11] == 20'h0 && busRdata[9:0] == 10'h0) else $error("status spare bits");
  a_ack_cause: assert property (busAck |-> $past(busRead || busWrite)) else $error("ack uncaused");
  a_led_dark: assert property (
    busAck && $past(busRead) && $past(ofs) == 32'h24 && !powerUpPhase
    && busRdata[14:13] == 2'h3 |-> !errorLed) else $error("led not dark");
  a_led_powerup: assert property (
    busAck && $past(busRead) && $past(ofs) == 32'h4 && powerUpPhase
    && !$past(errSummarySet) |-> errorLed == busRdata[31]) else $error("led not summary");
endmodule : err_status_asserts
bind error_led_selftest_status err_status_asserts chk_u (.clk(clk), .rst_b(rst_b), .slotNum(slotNum),
  .powerUpPhase(powerUpPhase), .errSummarySet(errSummarySet), .busAddr(busAddr), .busRead(busRead),
  .busWrite(busWrite), .busRdata(busRdata), .busAck(busAck), .errorLed(errorLed));
`default_nettype wire

//--- sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk, // Clock
  input wire logic [31:0] busRdata, // Read data
  input wire logic busAck, // Ack
  output logic [31:0] busAddr, // Address
  output logic busRead, // Read
  output logic busWrite, // Write
  output logic [31:0] busWdata // Write data
);
  // Idle bus
  initial {busRead, busWrite, busAddr, busWdata} = 66'h0;
  // One longword access, answer taken in the ack cycle
  // result data only compared, never acted on
  task automatic acc(input logic wr, input logic [31:0] a, d, output logic [31:0] q, output logic ok);
    @(negedge clk);
    busAddr = a;
    busWdata = d;
    busRead = !wr;
    busWrite = wr;
    @(negedge clk);
    {busRead, busWrite} = 2'h0;
    busAddr = ~a; // Released lines show no stale value
    busWdata = ~d;
    ok = busAck;
    q = busRdata;
  endtask : acc
endmodule : host_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] slotNum = 4'h1;
  logic isBootProc = 1'b1;
  logic powerUpPhase = 1'b1;
  logic cacheOff = 1'b0;
  logic errSummarySet = 1'b0;
  logic failValid = 1'b0;
  err_status_pkg::fail_family_e failFamily = err_status_pkg::FAM_SELFTEST;
  logic [6:0] failTestNum = 7'h0;
  logic [31:0] busAddr, busWdata, busRdata, q;
  logic busRead, busWrite, busAck, errorLed, ok, e;
  logic [31:0] base = 32'hE1880000;
  int n_errors = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  error_led_selftest_status dut_u (.clk(clk), .rst_b(rst_b), .slotNum(slotNum), .isBootProc(isBootProc),
    .powerUpPhase(powerUpPhase), .cacheOff(cacheOff), .errSummarySet(errSummarySet), .failValid(failValid),
    .failFamily(failFamily), .failTestNum(failTestNum), .busAddr(busAddr), .busRead(busRead),
    .busWrite(busWrite), .busWdata(busWdata), .busRdata(busRdata), .busAck(busAck), .errorLed(errorLed));
  host_model host_u (.clk(clk), .busRdata(busRdata), .busAck(busAck), .busAddr(busAddr), .busRead(busRead),
    .busWrite(busWrite), .busWdata(busWdata));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [31:0] o, exp, m);
    host_u.acc(1'b0, base + o, 32'h0, q, ok);
    chk("ack", {31'h0, ok}, 32'h1);
    chk("rdata", q & m, exp);
  endtask : rd
  task automatic wr(input logic [31:0] o, d);
    host_u.acc(1'b1, base + o, d, q, ok);
    chk("wack", {31'h0, ok}, 32'h1);
  endtask : wr
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  // Report a failure, then read result byte and bit 10
  task automatic fail(input err_status_pkg::fail_family_e f, input logic [6:0] n, input logic [7:0] x, input logic b);
    failFamily = f;
    failTestNum = n;
    pulse(failValid);
    rd(32'hC, {x, 24'h0}, 32'hFF000000);
    rd(32'h4, {21'h0, b, 10'h0}, 32'h00000400);
  endtask : fail
  task automatic results;
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // Watchdog
  initial begin
    #50000;
    n_errors++;
    results();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    rd(32'h24, 32'h0, 32'hFFFFFFFF);
    rd(32'h4, 32'h0, 32'hFFFFFFFF);
    pulse(errSummarySet);
    rd(32'h4, 32'h80000000, 32'hFFFFFFFF);
    wr(32'h4, 32'h80000000);
    chk("led", {31'h0, errorLed}, 32'h0);
    powerUpPhase = 1'b0;
    // every select with each summary and cache state
    for (int i = 0; i < 16; i++) begin
      cacheOff = i[2];
      wr(32'h24, {17'h0, i[1:0], 13'h0});
      wr(32'h4, 32'h80000000);
      if (i[3]) pulse(errSummarySet);
      rd(32'h24, {17'h0, i[1:0], 13'h0}, 32'hFFFFFFFF);
      e = i[1] ? (!i[0] && (i[3] || i[2])) : (i[0] ? i[2] : i[3]);
      chk("led", {31'h0, errorLed}, {31'h0, e});
    end
    powerUpPhase = 1'b1;
    @(negedge clk);
    chk("led", {31'h0, errorLed}, 32'h1);
    for (int s = 1; s < 15; s++) begin
      slotNum = 4'(s);
      base = 32'hE1880000 + 32'(s - 1) * 32'h80000;
      rd(32'h24, 32'h00006000, 32'hFFFFFFFF);
    end
    host_u.acc(1'b0, 32'hE1880024, 32'h0, q, ok);
    chk("miss", {31'h0, ok}, 32'h0);
    host_u.acc(1'b0, base + 32'h8, 32'h0, q, ok);
    chk("miss", {31'h0, ok}, 32'h0);
    // Slots 0 and 15 have no window
    slotNum = 4'h0;
    host_u.acc(1'b0, 32'hE1800024, 32'h0, q, ok);
    chk("slot0", {31'h0, ok}, 32'h0);
    slotNum = 4'hF;
    host_u.acc(1'b0, 32'hE1F80024, 32'h0, q, ok);
    chk("slot15", {31'h0, ok}, 32'h0);
    slotNum = 4'hE;
    // Result register is plain storage below the failure byte
    wr(32'hC, 32'h12345678);
    rd(32'hC, 32'h12345678, 32'hFFFFFFFF);
    fail(err_status_pkg::FAM_SELFTEST, 7'h01, 8'h01, 1'b1);
    rd(32'hC, 32'h01345678, 32'hFFFFFFFF);
    fail(err_status_pkg::FAM_CPU_MEM, 7'h16, 8'h82, 1'b0);
    fail(err_status_pkg::FAM_MULTIPROC, 7'h07, 8'h97, 1'b0);
    fail(err_status_pkg::FAM_ADAPTER, 7'h30, 8'h48, 1'b0);
    isBootProc = 1'b0;
    fail(err_status_pkg::FAM_ADAPTER, 7'h0D, 8'h48, 1'b0);
    fail(err_status_pkg::FAM_SELFTEST, 7'h39, 8'h57, 1'b1);
    // Mid-run reset clears every register
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    rd(32'hC, 32'h0, 32'hFFFFFFFF);
    rd(32'h4, 32'h0, 32'hFFFFFFFF);
    rd(32'h24, 32'h0, 32'hFFFFFFFF);
    results();
  end
endmodule : tb_top
`default_nettype wire
